// *** verilog/safe_consts.svh ***
// Purpose: named offsets, fields, reset values and timing of the sensor front-end config bank
// Assumes: ref_clk at 20 MHz
// Notes:   included by bare name; definitions only
`ifndef SAFE_CONSTS_SVH
`define SAFE_CONSTS_SVH

// fixed seven-bit slave address, identical for every device
`define SAFE_I2C_ADDR   7'h48

// register pointers
`define SAFE_OFS_STATUS 8'h00
`define SAFE_OFS_WPROT  8'h01
`define SAFE_OFS_GAIN   8'h10
`define SAFE_OFS_REF    8'h11
`define SAFE_OFS_MODE   8'h12

// power-on register contents
`define SAFE_RST_WPROT  8'h01
`define SAFE_RST_GAIN   8'h03
`define SAFE_RST_REF    8'h20
`define SAFE_RST_MODE   8'h00

// field positions
`define SAFE_F_READY    0
`define SAFE_F_WPROT    0
`define SAFE_F_FB       4:2
`define SAFE_F_LOAD     1:0
`define SAFE_F_REFEXT   7
`define SAFE_F_ZERO     6:5
`define SAFE_F_BSIGN    4
`define SAFE_F_BIAS     3:0
`define SAFE_F_SHORT    7
`define SAFE_F_OPMODE   2:0

// operating mode codes and the zero bypass code
`define SAFE_MODE_SLEEP 3'h0
`define SAFE_MODE_2LEAD 3'h1
`define SAFE_MODE_STBY  3'h2
`define SAFE_MODE_3LEAD 3'h3
`define SAFE_MODE_TOFF  3'h6
`define SAFE_MODE_TON   3'h7
`define SAFE_ZERO_BYP   2'h3

// serial byte framing
`define SAFE_BYTE_BITS  4'h8
`define SAFE_LAST_TX    4'h7

// power-on settle time and its cycle count (rounded up)
`define SAFE_CLK_NS     50
`define SAFE_POR_NS     10000
`define SAFE_POR_CYC    ((`SAFE_POR_NS + `SAFE_CLK_NS - 1) / `SAFE_CLK_NS)

`endif

// *** verilog/safe_pkg.sv ***
// Purpose: shared types of the sensor front-end config bank
// Assumes: nothing beyond the constants header
// Notes:   types only; numbers live in safe_consts.svh
package safe_pkg;

  // serial slave sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_PTR, ST_PTR_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RACK
  } safe_state_t;

  // stored configuration fields
  typedef struct packed {
    logic       wprot;
    logic [2:0] fb_sel;
    logic [1:0] load_sel;
    logic       ref_ext;
    logic [1:0] zero_sel;
    logic       bias_pos;
    logic [3:0] bias_sel;
    logic       short_en;
    logic [2:0] operating_mode_field;
  } safe_cfg_t;

  // decoded analog controls
  typedef struct packed {
    logic        ctrl_amp_on;
    logic        amp_on;
    logic        temp_on;
    logic        zero_bypass;
    logic        analog_output_pin_temp;
    logic        c2_pot;
    logic        ref_ext;
    logic        bias_pos;
    logic        short_en;
    logic [18:0] fb_ohms;
    logic [6:0]  load_ohms;
    logic [6:0]  zero_pct;
    logic [4:0]  bias_pct;
  } safe_ana_t;

endpackage

// *** verilog/safe_line_mon.sv ***
// Purpose: edge, start and stop detection on the serial clock and data lines
// Assumes: line inputs already synchronous to ref_clk
// Notes:   pulses are combinational from current and previous samples
`timescale 1ns/1ps
`default_nettype none
module safe_line_mon (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // line samples
  input  wire logic scl_i,
  input  wire logic sda_i,
  // events
  output var  logic scl_rise,
  output var  logic scl_fall,
  output var  logic start_det,
  output var  logic stop_det
);
  logic scl_q;
  logic sda_q;
  logic scl_d;
  logic sda_d;

  // previous-sample next values
  always_comb begin
    scl_d = scl_i;
    sda_d = sda_i;
  end

  // idle bus level after reset avoids a false start
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl_d;
      sda_q <= sda_d;
    end
  end

  // data moving while clock high marks start or stop
  always_comb begin
    scl_rise  = scl_i & ~scl_q;
    scl_fall  = ~scl_i & scl_q;
    start_det = scl_i & scl_q & sda_q & ~sda_i;
    stop_det  = scl_i & scl_q & ~sda_q & sda_i;
  end
endmodule
`default_nettype wire

// *** verilog/safe_field_dec.sv ***
// Purpose: decode stored fields into analog control settings
// Assumes: purely combinational; caller registers the result
// Notes:   unlisted mode codes fall back to the deep sleep set
`timescale 1ns/1ps
`default_nettype none
`include "safe_consts.svh"
module safe_field_dec (
  // stored fields
  input  wire safe_pkg::safe_cfg_t cfg,
  // decoded controls
  output var  safe_pkg::safe_ana_t ana
);
  // feedback resistor, zero means external part between filter pins
  function automatic logic [18:0] fb_ohms_of(input logic [2:0] c);
    case (c)
      3'h1:    fb_ohms_of = 19'h00ABE;
      3'h2:    fb_ohms_of = 19'h00DAC;
      3'h3:    fb_ohms_of = 19'h01B58;
      3'h4:    fb_ohms_of = 19'h036B0;
      3'h5:    fb_ohms_of = 19'h088B8;
      3'h6:    fb_ohms_of = 19'h1D4C0;
      3'h7:    fb_ohms_of = 19'h55730;
      default: fb_ohms_of = 19'h00000;
    endcase
  endfunction

  // bias percent; codes past nine hold the top step
  function automatic logic [4:0] bias_pct_of(input logic [3:0] c);
    case (c)
      4'h0:    bias_pct_of = 5'h00;
      4'h1:    bias_pct_of = 5'h01;
      4'h2:    bias_pct_of = 5'h02;
      4'h3:    bias_pct_of = 5'h04;
      4'h4:    bias_pct_of = 5'h06;
      4'h5:    bias_pct_of = 5'h08;
      4'h6:    bias_pct_of = 5'h0A;
      4'h7:    bias_pct_of = 5'h0C;
      4'h8:    bias_pct_of = 5'h0E;
      default: bias_pct_of = 5'h10;
    endcase
  endfunction

  // field and mode decode
  always_comb begin
    ana             = '0;
    ana.fb_ohms     = fb_ohms_of(cfg.fb_sel);
    case (cfg.load_sel)
      2'h0:    ana.load_ohms = 7'h0A;
      2'h1:    ana.load_ohms = 7'h21;
      2'h2:    ana.load_ohms = 7'h32;
      default: ana.load_ohms = 7'h64;
    endcase
    // fractions scale from the external pin when selected
    ana.ref_ext     = cfg.ref_ext;
    case (cfg.zero_sel)
      2'h0:    ana.zero_pct = 7'h14;
      2'h1:    ana.zero_pct = 7'h32;
      2'h2:    ana.zero_pct = 7'h43;
      default: ana.zero_pct = 7'h00;
    endcase
    ana.zero_bypass = (cfg.zero_sel == `SAFE_ZERO_BYP);
    ana.bias_pos    = cfg.bias_pos;
    ana.bias_pct    = bias_pct_of(cfg.bias_sel);
    ana.short_en    = cfg.short_en;
    case (cfg.operating_mode_field)
      `SAFE_MODE_2LEAD: ana.amp_on = 1'b1;
      `SAFE_MODE_STBY:  ana.ctrl_amp_on = 1'b1;
      `SAFE_MODE_3LEAD: begin
        ana.ctrl_amp_on = 1'b1;
        ana.amp_on      = 1'b1;
      end
      `SAFE_MODE_TOFF: begin
        ana.ctrl_amp_on = 1'b1;
        ana.temp_on     = 1'b1;
      end
      `SAFE_MODE_TON: begin
        ana.ctrl_amp_on = 1'b1;
        ana.amp_on      = 1'b1;
        ana.temp_on     = 1'b1;
        ana.analog_output_pin_temp   = 1'b1;
        ana.c2_pot      = 1'b1;
      end
      default: ana.ctrl_amp_on = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// *** verilog/safe_cfg_top.sv ***
// Purpose: config register bank of a sensor front end behind a two-wire serial slave
// Assumes: scl_i, sda_i and module_enable_n synchronous to ref_clk
// Notes:   sda is open drain; sda_oe high pulls the line low
// Contract
// - status bit 0 reads 0 after reset, then 1 once ready.
// - protect bit 0 of 0x01; 1 (reset) blocks writes to 0x10 and 0x11.
// - feedback code 4:2 picks external or 2.75k up to 350k ohms.
// - load code 1:0 picks 10, 33, 50, 100 ohms; reset 11.
// - reference bit 7 picks supply-derived (0) or external pin (1).
// - external reference scales both zero and bias levels.
// - zero code 6:5 is 20, 50, 67 percent or bypass.
// - reference bit 4 sets bias polarity, 1 positive.
// - bias code 3:0 gives 0 to 16 percent of the reference.
// - mode bit 7 enables the shorting switch.
// - mode code 2:0 selects sleep, two-lead, standby, three-lead, temperature.
// - temperature with amplifier on routes sensor to output, potentiostat to C2.
// - bus traffic ignored while module_enable_n is high.
// - only the enabled device acknowledges; address identical for all.
// - answer only the fixed address 1001000.
// - write: address+W, pointer, data, stop; each byte acknowledged.
// - read: set pointer, repeated start, address+R, device sends byte.
`timescale 1ns/1ps
`default_nettype none
`include "safe_consts.svh"
module safe_cfg_top (
  // clock and reset
  input  wire logic                ref_clk,
  input  wire logic                srst,
  // select and serial lines
  input  wire logic                module_enable_n,
  input  wire logic                scl_i,
  input  wire logic                sda_i,
  output var  logic                sda_o,
  output var  logic                sda_oe,
  // state and settings
  output var  logic                power_ready,
  output var  safe_pkg::safe_cfg_t cfg,
  output var  safe_pkg::safe_ana_t ana
);
  localparam logic [7:0] RST_WPROT = `SAFE_RST_WPROT, RST_GAIN = `SAFE_RST_GAIN;
  localparam logic [7:0] RST_REF   = `SAFE_RST_REF,   RST_MODE = `SAFE_RST_MODE;
  localparam safe_pkg::safe_cfg_t CFG_RST = '{
    wprot:    RST_WPROT[`SAFE_F_WPROT],
    fb_sel:   RST_GAIN[`SAFE_F_FB],
    load_sel: RST_GAIN[`SAFE_F_LOAD],
    ref_ext:  RST_REF[`SAFE_F_REFEXT],
    zero_sel: RST_REF[`SAFE_F_ZERO],
    bias_pos: RST_REF[`SAFE_F_BSIGN],
    bias_sel: RST_REF[`SAFE_F_BIAS],
    short_en: RST_MODE[`SAFE_F_SHORT],
    operating_mode_field:  RST_MODE[`SAFE_F_OPMODE]
  };
  localparam logic [7:0] POR_LAST = 8'(`SAFE_POR_CYC - 1);

  safe_pkg::safe_state_t st_q, st_d;
  safe_pkg::safe_cfg_t   cfg_q, cfg_d;
  safe_pkg::safe_ana_t   ana_q, ana_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [7:0] ptr_q, ptr_d;
  logic       rw_q, rw_d;
  logic       nack_q, nack_d;
  logic       oe_q, oe_d;
  logic       sda_o_q;
  logic [7:0] por_q, por_d;
  logic       rdy_q, rdy_d;
  logic [7:0] rd_now;
  logic       scl_rise, scl_fall, start_det, stop_det;
  logic       wr_now;

  // store a data byte; reserved bits are not kept
  function automatic safe_pkg::safe_cfg_t wr_cfg(input safe_pkg::safe_cfg_t c,
                                                 input logic [7:0] p,
                                                 input logic [7:0] v);
    wr_cfg = c;
    case (p)
      `SAFE_OFS_WPROT: wr_cfg.wprot = v[`SAFE_F_WPROT];
      `SAFE_OFS_GAIN: begin
        if (!c.wprot) begin
          wr_cfg.fb_sel   = v[`SAFE_F_FB];
          wr_cfg.load_sel = v[`SAFE_F_LOAD];
        end
      end
      `SAFE_OFS_REF: begin
        if (!c.wprot) begin
          wr_cfg.ref_ext  = v[`SAFE_F_REFEXT];
          wr_cfg.zero_sel = v[`SAFE_F_ZERO];
          wr_cfg.bias_pos = v[`SAFE_F_BSIGN];
          wr_cfg.bias_sel = v[`SAFE_F_BIAS];
        end
      end
      `SAFE_OFS_MODE: begin
        wr_cfg.short_en = v[`SAFE_F_SHORT];
        wr_cfg.operating_mode_field  = v[`SAFE_F_OPMODE];
      end
      default: wr_cfg = c;
    endcase
  endfunction

  // readback image; reserved bits and unmapped pointers read zero
  function automatic logic [7:0] rd_byte(input safe_pkg::safe_cfg_t c,
                                         input logic [7:0] p,
                                         input logic r);
    rd_byte = 8'h00;
    case (p)
      `SAFE_OFS_STATUS: rd_byte[`SAFE_F_READY] = r;
      `SAFE_OFS_WPROT:  rd_byte[`SAFE_F_WPROT] = c.wprot;
      `SAFE_OFS_GAIN: begin
        rd_byte[`SAFE_F_FB]   = c.fb_sel;
        rd_byte[`SAFE_F_LOAD] = c.load_sel;
      end
      `SAFE_OFS_REF: begin
        rd_byte[`SAFE_F_REFEXT] = c.ref_ext;
        rd_byte[`SAFE_F_ZERO]   = c.zero_sel;
        rd_byte[`SAFE_F_BSIGN]  = c.bias_pos;
        rd_byte[`SAFE_F_BIAS]   = c.bias_sel;
      end
      `SAFE_OFS_MODE: begin
        rd_byte[`SAFE_F_SHORT]  = c.short_en;
        rd_byte[`SAFE_F_OPMODE] = c.operating_mode_field;
      end
      default: rd_byte = 8'h00;
    endcase
  endfunction

  safe_line_mon u_line (
    .ref_clk   (ref_clk),
    .srst      (srst),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .scl_rise  (scl_rise),
    .scl_fall  (scl_fall),
    .start_det (start_det),
    .stop_det  (stop_det)
  );

  safe_field_dec u_dec (
    .cfg (cfg_q),
    .ana (ana_d)
  );

  assign rd_now = rd_byte(cfg_q, ptr_q, rdy_q);
  // a full data byte is committed only once the part reports ready
  assign wr_now = !module_enable_n && !start_det && !stop_det && (st_q == safe_pkg::ST_WDATA)
                  && scl_fall && (cnt_q == `SAFE_BYTE_BITS) && rdy_q;

  // power-on settle counter
  always_comb begin
    por_d = por_q;
    rdy_d = rdy_q;
    if (!rdy_q) begin
      if (por_q == POR_LAST) begin
        rdy_d = 1'b1;
      end else begin
        por_d = por_q + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      por_q <= 8'h00;
      rdy_q <= 1'b0;
    end else begin
      por_q <= por_d;
      rdy_q <= rdy_d;
    end
  end

  // serial slave sequencer; data shifts in on rise, sda moves on fall
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    ptr_d  = ptr_q;
    rw_d   = rw_q;
    nack_d = nack_q;
    oe_d   = oe_q;
    cfg_d  = cfg_q;
    if (module_enable_n) begin
      st_d = safe_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else if (start_det) begin
      st_d  = safe_pkg::ST_ADDR; // repeated start lands here too
      cnt_d = 4'h0;
      oe_d  = 1'b0;
    end else if (stop_det) begin
      st_d = safe_pkg::ST_IDLE;
      oe_d = 1'b0;
    end else begin
      case (st_q)
        safe_pkg::ST_IDLE: st_d = safe_pkg::ST_IDLE;
        safe_pkg::ST_ADDR, safe_pkg::ST_PTR, safe_pkg::ST_WDATA: begin
          if (scl_rise && cnt_q != `SAFE_BYTE_BITS) begin
            sh_d  = {sh_q[6:0], sda_i};
            cnt_d = cnt_q + 4'h1;
          end
          if (scl_fall && cnt_q == `SAFE_BYTE_BITS) begin
            oe_d  = 1'b1;
            cnt_d = 4'h0;
            if (st_q == safe_pkg::ST_ADDR) begin
              if (sh_q[7:1] == `SAFE_I2C_ADDR) begin
                rw_d = sh_q[0];
                st_d = safe_pkg::ST_ADDR_ACK;
              end else begin
                oe_d = 1'b0;
                st_d = safe_pkg::ST_IDLE;
              end
            end else if (st_q == safe_pkg::ST_PTR) begin
              ptr_d = sh_q;
              st_d  = safe_pkg::ST_PTR_ACK;
            end else begin
              if (wr_now) begin
                cfg_d = wr_cfg(cfg_q, ptr_q, sh_q);
              end
              st_d = safe_pkg::ST_WDATA_ACK;
            end
          end
        end
        safe_pkg::ST_ADDR_ACK, safe_pkg::ST_PTR_ACK, safe_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            oe_d = 1'b0;
            if (st_q == safe_pkg::ST_ADDR_ACK && rw_q) begin
              sh_d = rd_now;
              oe_d = ~rd_now[7];
              st_d = safe_pkg::ST_RDATA;
            end else if (st_q == safe_pkg::ST_ADDR_ACK) begin
              st_d = safe_pkg::ST_PTR;
            end else begin
              st_d = safe_pkg::ST_WDATA; // extra bytes rewrite the same pointer
            end
          end
        end
        safe_pkg::ST_RDATA: begin
          if (scl_fall) begin
            if (cnt_q == `SAFE_LAST_TX) begin
              oe_d = 1'b0;
              st_d = safe_pkg::ST_RACK;
            end else begin
              cnt_d = cnt_q + 4'h1;
              sh_d  = {sh_q[6:0], 1'b0};
              oe_d  = ~sh_q[6];
            end
          end
        end
        safe_pkg::ST_RACK: begin
          if (scl_rise) begin
            nack_d = sda_i;
          end
          if (scl_fall) begin
            if (nack_q) begin
              st_d = safe_pkg::ST_IDLE;
            end else begin
              sh_d  = rd_now; // pointer does not advance
              oe_d  = ~rd_now[7];
              cnt_d = 4'h0;
              st_d  = safe_pkg::ST_RDATA;
            end
          end
        end
        default: st_d = safe_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_q    <= safe_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
      sh_q    <= 8'h00;
      ptr_q   <= `SAFE_OFS_STATUS;
      rw_q    <= 1'b0;
      nack_q  <= 1'b0;
      oe_q    <= 1'b0;
      cfg_q   <= CFG_RST;
      ana_q   <= '0;
      sda_o_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      sh_q    <= sh_d;
      ptr_q   <= ptr_d;
      rw_q    <= rw_d;
      nack_q  <= nack_d;
      oe_q    <= oe_d;
      cfg_q   <= cfg_d;
      ana_q   <= ana_d;
      sda_o_q <= 1'b0;
    end
  end

  // outputs straight from flops
  assign sda_o       = sda_o_q;
  assign sda_oe      = oe_q;
  assign power_ready = rdy_q;
  assign cfg         = cfg_q;
  assign ana         = ana_q;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  AST_READY_LOW_AFTER_RESET: assert property ($fell(srst) |-> !power_ready)
    else $error("ready set right after reset");
  AST_READY_STICKS: assert property (power_ready |=> power_ready)
    else $error("ready dropped");
  AST_PROTECT_HOLDS: assert property (cfg_q.wprot |=>
      ($stable({cfg_q.fb_sel, cfg_q.load_sel, cfg_q.ref_ext, cfg_q.zero_sel,
                cfg_q.bias_pos, cfg_q.bias_sel})))
    else $error("protected field changed");
  AST_PROTECTED_STILL_ACKS: assert property ((wr_now && cfg_q.wprot) |=> sda_oe)
    else $error("protected write not acknowledged");
  AST_DISABLED_SILENT: assert property (module_enable_n |=> !sda_oe [*2])
    else $error("drives sda while disabled");
  AST_ADDR_MATCH_ACK: assert property ((!module_enable_n && !start_det && !stop_det
      && st_q == safe_pkg::ST_ADDR && scl_fall && cnt_q == `SAFE_BYTE_BITS
      && sh_q[7:1] == `SAFE_I2C_ADDR) |=> sda_oe && st_q == safe_pkg::ST_ADDR_ACK)
    else $error("own address not acknowledged");
  AST_ADDR_MISS_NACK: assert property ((st_q == safe_pkg::ST_ADDR && scl_fall
      && cnt_q == `SAFE_BYTE_BITS && sh_q[7:1] != `SAFE_I2C_ADDR) |=> !sda_oe)
    else $error("foreign address acknowledged");
  AST_MODE_WRITE: assert property ((wr_now && ptr_q == `SAFE_OFS_MODE) |=>
      cfg_q.operating_mode_field == $past(sh_q[2:0]) && cfg_q.short_en == $past(sh_q[7]))
    else $error("mode write lost");
  AST_UNLOCKED_GAIN: assert property ((wr_now && !cfg_q.wprot && ptr_q == `SAFE_OFS_GAIN)
      |=> cfg_q.fb_sel == $past(sh_q[4:2]) ##1 ana_q.fb_ohms == ana_d.fb_ohms)
    else $error("unlocked gain write lost");
  AST_TEMP_ROUTE: assert property (cfg_q.operating_mode_field == `SAFE_MODE_TON |=>
      ana_q.analog_output_pin_temp && ana_q.c2_pot && ana_q.temp_on && ana_q.amp_on)
    else $error("temperature routing wrong");
  AST_ACK_RELEASE: assert property ((st_q == safe_pkg::ST_WDATA_ACK && scl_fall
      && !module_enable_n && !start_det && !stop_det) |=> !sda_oe)
    else $error("ack not released");

  COV_WRITE:  cover property (wr_now ##1 st_q == safe_pkg::ST_WDATA_ACK);
  COV_READ:   cover property (st_q == safe_pkg::ST_RDATA ##[1:400] st_q == safe_pkg::ST_RACK);
  COV_LOCKED: cover property (wr_now && cfg_q.wprot && ptr_q == `SAFE_OFS_REF);
  COV_TEMP:   cover property (ana_q.analog_output_pin_temp);
endmodule
`default_nettype wire

// *** test/safe_host_model.sv ***
// Purpose: two-wire bus master standing in for the host controller
// Assumes: pull-up on the data line; device output enable pulls it low
// Notes:   moves lines just after falling ref_clk edges, three cycles apart
`timescale 1ns/1ps
`default_nettype none
module safe_host_model (
  // clock
  input  wire logic ref_clk,
  // bus lines
  input  wire logic sda_oe,
  output var  logic scl,
  output var  logic sda
);
  logic pull;

  // open drain: any party pulling wins, otherwise the pull-up
  assign sda = ~(pull | sda_oe);

  // idle bus at time zero
  initial begin
    scl  = 1'b1;
    pull = 1'b0;
  end

  // spacing keeps line changes well above the two-cycle minimum
  task automatic tick();
    repeat (3) @(negedge ref_clk);
  endtask

  // one bit slot; data moves only while the clock is low
  task automatic slot(input logic b, output logic r);
    pull = ~b;
    tick();
    scl = 1'b1;
    tick();
    r = sda;
    scl = 1'b0;
    tick();
  endtask

  // start or repeated start: data falls while the clock is high
  task automatic start();
    pull = 1'b0;
    tick();
    scl = 1'b1;
    tick();
    pull = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask

  // stop: data rises while the clock is high, bus left idle
  task automatic stop();
    pull = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    pull = 1'b0;
    tick();
  endtask

  // eight bits msb first, then the ack slot; n counts device acks
  task automatic byte9(input logic [7:0] d, input logic m, output logic [7:0] q, inout int n);
    logic a;
    for (int i = 7; i >= 0; i--) slot(d[i], q[i]);
    slot(m, a);
    n += int'(!a);
  endtask

  // address+W, pointer, data, stop
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v,
                    output int n);
    logic [7:0] q;
    n = 0;
    start();
    byte9({a, 1'b0}, 1'b1, q, n);
    byte9(p, 1'b1, q, n);
    byte9(v, 1'b1, q, n);
    stop();
  endtask

  // pointer set, repeated start, address+R, one byte closed by a nack
  task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] v,
                    output int n);
    logic [7:0] q;
    n = 0;
    start();
    byte9({a, 1'b0}, 1'b1, q, n);
    byte9(p, 1'b1, q, n);
    start();
    byte9({a, 1'b1}, 1'b1, q, n);
    byte9(8'hFF, 1'b1, v, n);
    stop();
  endtask
endmodule
`default_nettype wire

// *** test/sensor_afe_config_registers_bench.sv ***
// Purpose: self-checking bench of the sensor front-end config bank
// Assumes: one device on the bus, host model moves lines on falling edges
// Notes:   every field code swept, then random values from a fixed seed
`timescale 1ns/1ps
`default_nettype none
`include "safe_consts.svh"
module sensor_afe_config_registers_bench;
  logic                ref_clk;
  logic                srst;
  logic                module_enable_n;
  logic                scl;
  logic                sda;
  logic                sda_oe;
  logic                sda_o;
  logic                power_ready;
  safe_pkg::safe_cfg_t cfg;
  safe_pkg::safe_ana_t ana;
  int                  errors;
  int                  n_checks;
  int                  n;
  logic [7:0]          v;
  logic [7:0]          w [3];
  logic [7:0]          ofs [6] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12, 8'h05};
  logic [7:0]          rv [6] = '{8'h01, 8'h01, 8'h03, 8'h20, 8'h00, 8'h00};
  safe_pkg::safe_cfg_t cfg_rst = {1'b1, 3'h0, 2'h3, 8'h20, 1'b0, 3'h0};

  safe_cfg_top i_safe_cfg_top (
    .ref_clk         (ref_clk),
    .srst            (srst),
    .module_enable_n (module_enable_n),
    .scl_i           (scl),
    .sda_i           (sda),
    .sda_o           (sda_o),
    .sda_oe          (sda_oe),
    .power_ready     (power_ready),
    .cfg             (cfg),
    .ana             (ana)
  );

  safe_host_model i_safe_host_model (
    .ref_clk (ref_clk),
    .sda_oe  (sda_oe),
    .scl     (scl),
    .sda     (sda)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // expected decode of the gain, reference and mode bytes
  task automatic chk_dec(input logic [7:0] g, input logic [7:0] r, input logic [7:0] m);
    int         fb [8] = '{0, 2750, 3500, 7000, 14000, 35000, 120000, 350000};
    int         ld [4] = '{10, 33, 50, 100};
    int         zp [4] = '{20, 50, 67, 0};
    int         bp [10] = '{0, 1, 2, 4, 6, 8, 10, 12, 14, 16};
    logic [2:0] md;
    md = m[2:0];
    chk(ana.fb_ohms, fb[g[4:2]]);
    chk(ana.load_ohms, ld[g[1:0]]);
    chk(ana.zero_pct, zp[r[6:5]]);
    chk(ana.bias_pct, bp[(r[3:0] > 4'h9) ? 4'h9 : r[3:0]]);
    chk({ana.ref_ext, ana.bias_pos, ana.short_en, ana.zero_bypass},
        {r[7], r[4], m[7], r[6:5] == 2'h3});
    chk({ana.ctrl_amp_on, ana.amp_on, ana.temp_on, ana.analog_output_pin_temp, ana.c2_pot},
        {md inside {3'h2, 3'h3, 3'h6, 3'h7}, md inside {3'h1, 3'h3, 3'h7},
         md inside {3'h6, 3'h7}, md == 3'h7, md == 3'h7});
  endtask

  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // watchdog, well above the expected run of about 50k cycles
  initial begin
    repeat (90000) @(posedge ref_clk);
    errors++;
    summarize();
  end

  // main sequence
  initial begin
    errors = 0;
    n_checks = 0;
    srst = 1'b1;
    module_enable_n = 1'b0;
    void'($urandom(98917));
    repeat (5) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    chk(cfg, cfg_rst);
    repeat (190) @(negedge ref_clk);
    chk(power_ready, 0);
    repeat (20) @(negedge ref_clk);
    chk(power_ready, 1);
    for (int i = 0; i < 6; i++) begin
      i_safe_host_model.rd(`SAFE_I2C_ADDR, ofs[i], v, n);
      chk(n, 3);
      chk(v, rv[i]);
    end
    // open drain: the driven level is always low
    chk(sda_o, 1'b0);
    // locked gain write is acked but changes nothing
    i_safe_host_model.wr(`SAFE_I2C_ADDR, 8'h10, 8'h1F, n);
    chk(n, 3);
    i_safe_host_model.rd(`SAFE_I2C_ADDR, 8'h10, v, n);
    chk(v, 8'h03);
    i_safe_host_model.wr(`SAFE_I2C_ADDR, 8'h01, 8'h00, n);
    // host loads gain, reference and mode; reserved bits written as zero
    for (int i = 0; i < 24; i++) begin
      if (i < 16) w = '{{3'h0, i[2:0], i[1:0]}, {i[3], i[1:0], i[2], i[3:0]},
                        {i[0], 4'h0, i[2:0]}};
      else w = '{8'($urandom) & 8'h1F, 8'($urandom), 8'($urandom) & 8'h87};
      for (int k = 0; k < 3; k++) begin
        i_safe_host_model.wr(`SAFE_I2C_ADDR, 8'h10 + 8'(k), w[k], n);
        chk(n, 3);
        i_safe_host_model.rd(`SAFE_I2C_ADDR, 8'h10 + 8'(k), v, n);
        chk(v, w[k]);
      end
      chk_dec(w[0], w[1], w[2]);
    end
    // sensor test: step the bias field, then put the original byte back
    i_safe_host_model.wr(`SAFE_I2C_ADDR, 8'h11, w[1] ^ 8'h01, n);
    chk_dec(w[0], w[1] ^ 8'h01, w[2]);
    i_safe_host_model.wr(`SAFE_I2C_ADDR, 8'h11, w[1], n);
    chk_dec(w[0], w[1], w[2]);
    // foreign address, then deselected device: neither answers
    i_safe_host_model.wr(`SAFE_I2C_ADDR ^ 7'(1 + $urandom_range(126)), 8'h12, 8'h01, n);
    chk(n, 0);
    module_enable_n = 1'b1;
    i_safe_host_model.wr(`SAFE_I2C_ADDR, 8'h12, 8'h01, n);
    chk(n, 0);
    module_enable_n = 1'b0;
    i_safe_host_model.rd(`SAFE_I2C_ADDR, 8'h12, v, n);
    chk(v, w[2]);
    // relocked: reference frozen, mode still writable
    i_safe_host_model.wr(`SAFE_I2C_ADDR, 8'h01, 8'h01, n);
    i_safe_host_model.wr(`SAFE_I2C_ADDR, 8'h11, ~w[1], n);
    i_safe_host_model.rd(`SAFE_I2C_ADDR, 8'h11, v, n);
    chk(v, w[1]);
    i_safe_host_model.wr(`SAFE_I2C_ADDR, 8'h12, 8'h83, n);
    i_safe_host_model.rd(`SAFE_I2C_ADDR, 8'h12, v, n);
    chk(v, 8'h83);
    // second reset in mid-run
    srst = 1'b1;
    repeat (2) @(negedge ref_clk);
    srst = 1'b0;
    @(negedge ref_clk);
    chk(cfg, cfg_rst);
    chk(power_ready, 0);
    summarize();
  end
endmodule
`default_nettype wire
